// ---- hdl/exec_unit.sv ----
// return, rotate-through-carry and sleep execution with an apb slave
// Summary of operation
// - return pops stack, stack top loads pc
// - return: one word, two cycles, flags kept
// - right rotate: carry into bit7, bit0 out
// - right rotate dest 0 to w, 1 back
// - left rotate: carry into bit0, bit7 out
// - left rotate dest 0 to w, 1 back
// - rotates take one cycle, change only carry
// - sleep clears watchdog counter and prescaler
// - sleep clears powerdown flag, sets timeout flag
// - sleep halts oscillator until wake event
//
// The address map and the APB interface to the registers were chosen for this implementation.
`include "exec_regs.svh"
module exec_unit #(
  parameter int STACK_DEPTH = 8, // return stack levels
  parameter int PC_W = 13 // program counter width
) (
  input wire logic CLK, // 100 mhz clock
  input wire logic NRST, // async reset, active low
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb access phase
  input wire logic PWRITE, // apb direction
  input wire logic [7:0] PADDR, // apb byte address
  input wire exec_pkg::word_type PWDATA, // apb write data
  output exec_pkg::word_type PRDATA, // apb read data
  output logic PREADY, // apb ready
  output logic PSLVERR, // apb error
  output logic SLEEPING // core halted in sleep
);
  import exec_pkg::*;
  localparam int SP_W = $clog2(STACK_DEPTH);

  exec_state_type state_ff, nxt_state;
  logic [1:0] div_ff;
  logic [13:0] instr_ff;
  logic [7:0] w_ff;
  logic c_ff, pd_n_ff, to_n_ff;
  logic [PC_W-1:0] pc_ff;
  logic [SP_W-1:0] sp_ff;
  logic [PC_W-1:0] stack_mem [STACK_DEPTH];
  logic [7:0] file_mem [128];
  logic [6:0] faddr_ff;
  logic [7:0] watchdog_counter, wdog_pre_ff;
  word_type prdata_ff;
  logic pready_ff, pslverr_ff, sleeping_ff;

  // bus decode
  wire setup = PSEL && !PENABLE;
  wire wr_acc = PSEL && PENABLE && PWRITE && pready_ff;
  wire hit_instr = PADDR == `OFS_INSTR;
  wire hit_w = PADDR == `OFS_WREG;
  wire hit_st = PADDR == `OFS_STATUS;
  wire hit_pc = PADDR == `OFS_PC;
  wire hit_fa = PADDR == `OFS_FADDR;
  wire hit_fd = PADDR == `OFS_FDATA;
  wire hit_stk = PADDR == `OFS_STACK;
  wire hit_wd = PADDR == `OFS_WDOG;
  wire mapped = hit_instr | hit_w | hit_st | hit_pc | hit_fa | hit_fd |
    hit_stk | hit_wd;
  wire busy = state_ff != ST_IDLE;
  // core state must not be poked mid-instruction
  wire refuse = !mapped || (busy && PWRITE && !hit_wd);
  wire do_wr = wr_acc && !pslverr_ff;
  wire issue = do_wr && hit_instr;
  wire wake = do_wr && hit_wd && PWDATA[`WAKE_BIT] && state_ff == ST_SLP;

  // instruction decode
  wire [5:0] op_hi = instr_ff[`OP_HI:`OP_LO];
  wire is_ret = instr_ff == `OP_RETURN;
  wire is_slp = instr_ff == `OP_SLEEP;
  wire is_rrf = op_hi == `OP_RRF;
  wire is_rlf = op_hi == `OP_RLF;
  wire is_rot = is_rrf || is_rlf;
  wire dest_f = instr_ff[`DEST_BIT];
  wire [6:0] fsel = instr_ff[`FADDR_HI:0];
  wire [7:0] src = file_mem[fsel];
  wire [7:0] rot_res = is_rrf ? {c_ff, src[7:1]} :
    {src[6:0], c_ff};
  wire rot_c = is_rrf ? src[0] : src[7];

  // instruction cycle enable; held while asleep as the oscillator stops
  wire cyc_en = div_ff == `DIV_LAST && state_ff != ST_SLP;
  wire exec_now = state_ff == ST_EXEC && cyc_en;
  wire ret_now = exec_now && is_ret;
  wire rot_now = exec_now && is_rot;
  wire slp_now = exec_now && is_slp;
  wire [SP_W-1:0] sp_dn = sp_ff - 1'b1;
  wire [PC_W-1:0] stack_top = stack_mem[sp_dn];
  wire pre_wrap = &wdog_pre_ff;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: if (issue) nxt_state = ST_EXEC;
      ST_EXEC: begin
        if (cyc_en) begin
          if (is_ret) nxt_state = ST_RET2;
          else if (is_slp) nxt_state = ST_SLP;
          else nxt_state = ST_IDLE;
        end
      end
      ST_RET2: if (cyc_en) nxt_state = ST_IDLE;
      ST_SLP: if (wake) nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) state_ff <= ST_IDLE;
    else state_ff <= nxt_state;
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) div_ff <= '0;
    else if (state_ff != ST_SLP) div_ff <= div_ff + 1'b1;
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) instr_ff <= '0;
    else if (issue) instr_ff <= PWDATA[13:0];
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) w_ff <= `W_RST;
    else if (rot_now && !dest_f) w_ff <= rot_res;
    else if (do_wr && hit_w) w_ff <= PWDATA[7:0];
  end

  // status: rotates touch carry only, sleep the two low-true flags
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      c_ff <= 1'b0;
      pd_n_ff <= 1'b1;
      to_n_ff <= 1'b1;
    end else if (rot_now) begin
      c_ff <= rot_c;
    end else if (slp_now) begin
      pd_n_ff <= 1'b0;
      to_n_ff <= 1'b1;
    end else if (do_wr && hit_st) begin
      c_ff <= PWDATA[`ST_C];
      pd_n_ff <= PWDATA[`ST_PD_N];
      to_n_ff <= PWDATA[`ST_TO_N];
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) pc_ff <= `PC_RST;
    else if (ret_now) pc_ff <= stack_top;
    else if (do_wr && hit_pc) pc_ff <= PWDATA[PC_W-1:0];
  end

  // stack pointer wraps, as a circular hardware stack does
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) sp_ff <= '0;
    else if (ret_now) sp_ff <= sp_dn;
    else if (do_wr && hit_stk) sp_ff <= sp_ff + 1'b1;
  end

  always_ff @(posedge CLK) begin
    if (do_wr && hit_stk) stack_mem[sp_ff] <= PWDATA[PC_W-1:0];
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) faddr_ff <= '0;
    else if (do_wr && hit_fa) faddr_ff <= PWDATA[6:0];
  end

  // file array has no reset, like real data ram
  always_ff @(posedge CLK) begin
    if (rot_now && dest_f) file_mem[fsel] <= rot_res;
    else if (do_wr && hit_fd) file_mem[faddr_ff] <= PWDATA[7:0];
  end

  // watchdog ticks from the core clock here, sleep restarts it
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      wdog_pre_ff <= `WDOG_CLR;
      watchdog_counter <= `WDOG_CLR;
    end else if (slp_now) begin
      wdog_pre_ff <= `WDOG_CLR;
      watchdog_counter <= `WDOG_CLR;
    end else begin
      wdog_pre_ff <= wdog_pre_ff + 1'b1;
      if (pre_wrap) watchdog_counter <= watchdog_counter + 1'b1;
    end
  end

  // read mux
  word_type rd_val;
  always_comb begin
    rd_val = '0;
    if (hit_instr) begin
      rd_val[`BUSY_BIT] = busy;
      rd_val[`SLEEP_BIT] = state_ff == ST_SLP;
    end
    if (hit_w) rd_val[7:0] = w_ff;
    if (hit_st) begin
      rd_val[`ST_C] = c_ff;
      rd_val[`ST_PD_N] = pd_n_ff;
      rd_val[`ST_TO_N] = to_n_ff;
    end
    if (hit_pc) rd_val[PC_W-1:0] = pc_ff;
    if (hit_fa) rd_val[6:0] = faddr_ff;
    if (hit_fd) rd_val[7:0] = file_mem[faddr_ff];
    if (hit_stk) rd_val[PC_W-1:0] = stack_top;
    if (hit_wd) rd_val[15:0] = {watchdog_counter, wdog_pre_ff};
  end

  // one access cycle: ready and data latched in the setup cycle
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      prdata_ff <= '0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup && refuse;
      if (setup && !PWRITE) prdata_ff <= rd_val;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) sleeping_ff <= 1'b0;
    else sleeping_ff <= nxt_state == ST_SLP;
  end

  assign PRDATA = prdata_ff;
  assign PREADY = pready_ff;
  assign PSLVERR = pslverr_ff;
  assign SLEEPING = sleeping_ff;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  sequence ret_start;
    ret_now;
  endsequence
  sequence ret_tail;
    (state_ff == ST_RET2) [*4] ##1 (state_ff == ST_IDLE);
  endsequence

  a_ret_loads_pc: assert property (
    ret_start |=> pc_ff == $past(stack_top) && sp_ff == $past(sp_dn))
    else $error("return did not load pc from stack top");

  a_ret_two_cycles: assert property (
    ret_start |=> ret_tail)
    else $error("return did not take two instruction cycles");

  a_ret_flags_kept: assert property (
    ret_start |=> $stable(c_ff) && $stable(pd_n_ff) && $stable(to_n_ff))
    else $error("return changed a status flag");

  a_rrf_result: assert property (
    rot_now && is_rrf |=> c_ff == $past(src[0]) &&
      (dest_f ? 1'b1 : w_ff == {$past(c_ff), $past(src[7:1])}))
    else $error("right rotate result or carry wrong");

  a_rlf_result: assert property (
    rot_now && is_rlf |=> c_ff == $past(src[7]) &&
      (dest_f ? 1'b1 : w_ff == {$past(src[6:0]), $past(c_ff)}))
    else $error("left rotate result or carry wrong");

  a_rot_dest_w: assert property (
    rot_now && !dest_f |=> $stable(file_mem[fsel]))
    else $error("rotate to w changed the source register");

  a_rot_dest_f: assert property (
    rot_now && dest_f |=> file_mem[$past(fsel)] == $past(rot_res)
      && $stable(w_ff))
    else $error("rotate to file wrote the wrong place");

  a_rot_one_cycle: assert property (
    rot_now |=> state_ff == ST_IDLE && $stable(pd_n_ff) &&
      $stable(to_n_ff))
    else $error("rotate took more than one cycle or hit flags");

  a_sleep_wdog: assert property (
    slp_now |=> watchdog_counter == `WDOG_CLR &&
      wdog_pre_ff == `WDOG_CLR)
    else $error("sleep did not clear the watchdog");

  a_sleep_flags: assert property (
    slp_now |=> !pd_n_ff && to_n_ff && $stable(c_ff))
    else $error("sleep set the status flags wrongly");

  a_sleep_halts: assert property (
    slp_now ##1 !wake |=> $stable(div_ff) && state_ff == ST_SLP
      && SLEEPING)
    else $error("clock kept running in sleep");

  // bus handshake: no wait states, ready and error pulse once
  sequence apb_setup;
    setup;
  endsequence
  sequence apb_answer;
    PREADY ##1 !PREADY;
  endsequence

  a_apb_ready_pulse: assert property (
    apb_setup |=> apb_answer)
    else $error("ready was not one pulse after setup");

  a_apb_err_ready: assert property (
    PSLVERR |-> PREADY)
    else $error("error response without ready");

  a_apb_unmapped_err: assert property (
    setup && !mapped |=> PSLVERR)
    else $error("unmapped access not refused");

  a_apb_unmapped_zero: assert property (
    setup && !mapped && !PWRITE |=> PRDATA == '0)
    else $error("unmapped read returned data");

  a_apb_busy_refused: assert property (
    setup && PWRITE && busy && !hit_wd |=> PSLVERR)
    else $error("write accepted while an instruction ran");

  a_apb_read_ok: assert property (
    setup && !PWRITE && mapped |=> !PSLVERR)
    else $error("mapped read was refused");

  a_rrf_to_file: assert property (
    rot_now && is_rrf && dest_f |=>
      file_mem[$past(fsel)] == {$past(c_ff), $past(src[7:1])})
    else $error("right rotate wrote the wrong value back");

  a_rlf_to_file: assert property (
    rot_now && is_rlf && dest_f |=>
      file_mem[$past(fsel)] == {$past(src[6:0]), $past(c_ff)})
    else $error("left rotate wrote the wrong value back");

  a_sleep_enters: assert property (
    slp_now |=> state_ff == ST_SLP && SLEEPING)
    else $error("sleep did not halt the core");

  a_sleep_frozen: assert property (
    state_ff == ST_SLP && !wake |=> $stable(pc_ff) && $stable(w_ff)
      && $stable(instr_ff))
    else $error("core state moved while asleep");

  a_wake_resumes: assert property (
    wake |=> state_ff == ST_IDLE && !SLEEPING)
    else $error("wake did not return the core to idle");

endmodule

// ---- hdl/exec_regs.svh ----
// register map, opcodes and field positions of the execution unit
`ifndef EXEC_REGS_SVH
`define EXEC_REGS_SVH
`define OFS_INSTR 8'h00
`define OFS_WREG 8'h04
`define OFS_STATUS 8'h08
`define OFS_PC 8'h0c
`define OFS_FADDR 8'h10
`define OFS_FDATA 8'h14
`define OFS_STACK 8'h18
`define OFS_WDOG 8'h1c
`define OP_RETURN 14'h0008
`define OP_SLEEP 14'h0063
`define OP_RRF 6'h0c
`define OP_RLF 6'h0d
`define OP_HI 13
`define OP_LO 8
`define DEST_BIT 7
`define FADDR_HI 6
`define ST_C 0
`define ST_PD_N 3
`define ST_TO_N 4
`define WAKE_BIT 0
`define BUSY_BIT 0
`define SLEEP_BIT 1
`define PC_RST 13'h0000
`define W_RST 8'h00
`define WDOG_CLR 8'h00
`define DIV_LAST 2'h3
`endif

// ---- hdl/exec_pkg.sv ----
// types shared by the execution unit
package exec_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_RET2 = 2'b10,
    ST_SLP = 2'b11
  } exec_state_type;
  typedef logic [31:0] word_type;
endpackage

// ---- tb/return_rotate_sleep_exec_tb_top.sv ----
// self-checking bench for the return, rotate and sleep execution unit
`include "exec_regs.svh"
module return_rotate_sleep_exec_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import exec_pkg::*;
  typedef struct packed {
    logic chk;
    word_type d;
    logic e;
  } note_type;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, sleeping;
  logic [7:0] paddr;
  word_type pwdata, prdata, rd_tmp;
  note_type notes[$];
  note_type nt;
  int err_total, comparisons, cyc, seed, t0;
  logic [6:0] f;
  logic [7:0] v, w0, res;
  logic c, d, left, nc;

  exec_unit i_dut (.CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .SLEEPING(sleeping));

  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic give_verdict();
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // watcher: every ready pulse retires the oldest note
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      err_total++;
      give_verdict();
    end
    if (pready === 1'b1) begin
      if (notes.size() == 0) begin
        check(1'b0, "ready without request");
      end else begin
        nt = notes.pop_front();
        check(pslverr === nt.e, "error response");
        if (nt.chk)
          check(prdata === nt.d, "read data");
      end
    end
  end

  task automatic xfer(input logic wr, input logic [7:0] a, input word_type wd,
      input logic chk, input word_type ed, input logic ee);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    notes.push_back('{chk, ed, ee});
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd_tmp = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input word_type dat, input logic ee);
    xfer(1'b1, a, dat, 1'b0, '0, ee);
  endtask

  task automatic rdx(input logic [7:0] a, input word_type ed);
    xfer(1'b0, a, '0, 1'b1, ed, 1'b0);
  endtask

  // polling keeps the bus busy, so timing checks are only lower bounds
  task automatic wait_bit(input int b, input logic lvl);
    do xfer(1'b0, `OFS_INSTR, '0, 1'b0, '0, 1'b0);
    while (rd_tmp[b] !== lvl);
  endtask

  initial begin
    seed = 48;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = '0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    rdx(`OFS_WREG, 32'h0);
    rdx(`OFS_STATUS, 32'h18);
    xfer(1'b0, 8'h20, '0, 1'b1, '0, 1'b1);
    for (int i = 0; i < 16; i++) begin
      f = (i < 2) ? 7'h7f : (i < 4) ? 7'h00 : 7'($random(seed));
      v = 8'($random(seed));
      w0 = 8'($random(seed));
      c = 1'($random(seed));
      d = i[0];
      left = i[1];
      res = left ? {v[6:0], c} : {c, v[7:1]};
      nc = left ? v[7] : v[0];
      wr(`OFS_WREG, {24'h0, w0}, 1'b0);
      wr(`OFS_FADDR, {25'h0, f}, 1'b0);
      wr(`OFS_FDATA, {24'h0, v}, 1'b0);
      wr(`OFS_STATUS, 32'h18 | c, 1'b0);
      wr(`OFS_INSTR, {18'h0, left ? `OP_RLF : `OP_RRF, d, f}, 1'b0);
      wait_bit(`BUSY_BIT, 1'b0);
      rdx(`OFS_WREG, {24'h0, d ? w0 : res});
      rdx(`OFS_FDATA, {24'h0, d ? res : v});
      rdx(`OFS_STATUS, 32'h18 | nc);
    end
    wr(`OFS_STACK, 32'h0123, 1'b0);
    wr(`OFS_STACK, 32'h1abc, 1'b0);
    wr(`OFS_STATUS, 32'h19, 1'b0);
    wr(`OFS_WREG, 32'h5a, 1'b0);
    wr(`OFS_INSTR, {18'h0, `OP_RETURN}, 1'b0);
    t0 = cyc;
    wr(`OFS_WREG, 32'ha5, 1'b1);
    // busy sampled five clocks after issue, idle sampled nine after
    rdx(`OFS_INSTR, 32'h1);
    @(posedge clk);
    rdx(`OFS_INSTR, 32'h0);
    wait_bit(`BUSY_BIT, 1'b0);
    check(cyc - t0 >= 5, "return finished too soon");
    rdx(`OFS_PC, 32'h1abc);
    rdx(`OFS_STACK, 32'h0123);
    rdx(`OFS_STATUS, 32'h19);
    rdx(`OFS_WREG, 32'h5a);
    wr(`OFS_STATUS, 32'h09, 1'b0);
    repeat (300) @(posedge clk);
    wr(`OFS_INSTR, {18'h0, `OP_SLEEP}, 1'b0);
    wait_bit(`SLEEP_BIT, 1'b1);
    check(sleeping === 1'b1, "not halted");
    rdx(`OFS_STATUS, 32'h11);
    xfer(1'b0, `OFS_WDOG, '0, 1'b0, '0, 1'b0);
    check(rd_tmp[15:8] === 8'h00, "watchdog not cleared");
    check(rd_tmp[7:0] < 8'h10, "prescaler not cleared");
    wr(`OFS_INSTR, {18'h0, `OP_RETURN}, 1'b1);
    wr(`OFS_WDOG, 32'h1, 1'b0);
    rdx(`OFS_INSTR, 32'h0);
    check(sleeping === 1'b0, "still halted after wake");
    // a second reset in mid-run must bring back the reset state
    nrst <= 1'b0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    rdx(`OFS_PC, 32'h0);
    rdx(`OFS_WREG, 32'h0);
    rdx(`OFS_STATUS, 32'h18);
    give_verdict();
  end
endmodule
